// [rtl/sptl_pkg.sv]
// Purpose: Shared constants and types for the serial-to-parallel latch driver
// Assumes: Frame of 14 bits, 13 outputs
// Notes: Definitions only
package sptl_pkg;
	localparam int FRAME_BITS = 14;
	localparam int OUT_BITS = 13;
	localparam logic [3:0] CNT_RST = 4'h0;
	localparam logic [3:0] CNT_FULL = 4'he;
	localparam logic [3:0] CNT_SAT = 4'hf;
	localparam logic [12:0] LATCH_RST = 13'h0000;
	localparam logic [13:0] CHAIN_RST = 14'h0000;
	localparam logic [1:0] SYNC_RST = 2'h0;

	typedef struct packed {
		logic [12:0] value;
		logic drive;
	} sptl_word_type;
endpackage

// [rtl/sptl_top.sv]
// Purpose: Serial-in, parallel-out latch driver with frame check
// Assumes: Host clock shift_clock_in may stop between frames
// Assumes: rst is held for at least three falling host clock edges
// Assumes: Host keeps data and enable steady around each falling edge
// Notes: Outputs float until the first valid frame reaches the latches
// Notes: A refused frame leaves every port exactly as it was
// Notes: Notes on behaviour below
// Notes on behaviour
// RULE1: Fourteen-stage shift chain feeds thirteen output latches.
// RULE2: Serial data sampled on each falling shift clock edge.
// RULE3: Chain shifts only while load window enable is high.
// RULE4: Host holds enable high exactly fourteen pulses, then low.
// RULE5: Host sends fourteen bits, first bit low, with the clock.
// RULE6: Frame valid only with fourteen enabled pulses and low first bit.
// RULE7: Valid frame loads thirteen bits on the fifteenth pulse.
// RULE8: Outputs hold latch levels until next valid transfer.
// RULE9: Reset clears state and floats all outputs.
// RULE10: Outputs first driven after first valid frame transfer.
// RULE11: Host clock may run freely or burst fifteen pulses. The first two falling edges after rst only release the link reset.
// RULE12: Bad frame leaves latches and float state unchanged.
// RULE13: Leading low bit is start marker; next bits map outputs one up.
`timescale 1ns/10ps
`default_nettype none
module sptl_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic shift_clock_in,
	input wire logic serial_data_in,
	input wire logic load_window_enable,
	output logic [12:0] driver_outputs,
	output logic [12:0] driver_outputs_oe
);
	import sptl_pkg::*;

	// Link domain, falling edge of host clock
	logic [1:0] lrst_sync_r;
	logic [13:0] shift_stage_chain_r;
	logic [3:0] bit_cnt_r;
	logic [3:0] bit_cnt_nxt;
	logic [12:0] stage_word_r;
	logic xfer_tgl_r;

	// Reset released into the link domain by two flops
	always_ff @(negedge shift_clock_in or posedge rst) begin
		if (rst) begin
			lrst_sync_r <= SYNC_RST;
		end else begin
			lrst_sync_r <= {lrst_sync_r[0], 1'b1};
		end
	end

	// Count saturates so an over-long window is refused
	always_comb begin
		bit_cnt_nxt = bit_cnt_r;
		if (load_window_enable && bit_cnt_r != CNT_SAT) begin
			bit_cnt_nxt = 4'(bit_cnt_r + 4'h1);
		end else if (!load_window_enable) begin
			bit_cnt_nxt = CNT_RST;
		end
	end

	always_ff @(negedge shift_clock_in) begin
		if (!lrst_sync_r[1]) begin
			shift_stage_chain_r <= CHAIN_RST;
		end else if (load_window_enable) begin
			shift_stage_chain_r <= {shift_stage_chain_r[12:0], serial_data_in}; // RULE2 RULE3 RULE1
		end
	end

	always_ff @(negedge shift_clock_in) begin
		if (!lrst_sync_r[1]) begin
			bit_cnt_r <= CNT_RST;
		end else begin
			bit_cnt_r <= bit_cnt_nxt;
		end
	end

	// Start bit sits at stage 13; line 0 is the stage below it
	logic [12:0] line_map;

	always_comb begin
		line_map[0] = shift_stage_chain_r[12]; // RULE13
		line_map[1] = shift_stage_chain_r[11];
		line_map[2] = shift_stage_chain_r[10];
		line_map[3] = shift_stage_chain_r[9];
		line_map[4] = shift_stage_chain_r[8];
		line_map[5] = shift_stage_chain_r[7];
		line_map[6] = shift_stage_chain_r[6];
		line_map[7] = shift_stage_chain_r[5];
		line_map[8] = shift_stage_chain_r[4];
		line_map[9] = shift_stage_chain_r[3];
		line_map[10] = shift_stage_chain_r[2];
		line_map[11] = shift_stage_chain_r[1];
		line_map[12] = shift_stage_chain_r[0];
	end

	// Fifteenth pulse: enable low after exactly 14, first bit low
	always_ff @(negedge shift_clock_in) begin
		if (!lrst_sync_r[1]) begin
			xfer_tgl_r <= 1'b0;
			stage_word_r <= LATCH_RST;
		end else if (!load_window_enable && bit_cnt_r == CNT_FULL
				&& !shift_stage_chain_r[13]) begin // RULE6 RULE7 RULE12
			// Word held still for many link edges while the toggle crosses
			stage_word_r <= line_map; // RULE13
			xfer_tgl_r <= ~xfer_tgl_r;
		end
	end

	// System domain: toggle crossing, word stable while toggle settles
	logic [2:0] tgl_sync_r;
	logic [12:0] word_hold_r;
	logic word_take;

	always_ff @(posedge clk) begin
		if (rst) begin
			tgl_sync_r <= 3'h0;
		end else begin
			tgl_sync_r <= {tgl_sync_r[1:0], xfer_tgl_r};
		end
	end

	assign word_take = tgl_sync_r[2] ^ tgl_sync_r[1];

	always_ff @(posedge clk) begin
		if (rst) begin
			word_hold_r <= LATCH_RST;
		end else if (word_take) begin
			word_hold_r <= stage_word_r;
		end
	end

	// Two-entry buffer between crossing and output latches
	sptl_word_type buf_mem_r [2];
	logic buf_wr_r;
	logic buf_rd_r;
	logic [1:0] buf_cnt_r;
	logic take_r;
	logic in_ready;
	logic out_valid;
	logic buf_push;
	logic buf_pop;

	assign in_ready = buf_cnt_r != 2'h2;
	assign out_valid = buf_cnt_r != 2'h0;
	// Output latches always accept, so a valid entry pops at once
	assign buf_push = take_r && in_ready;
	assign buf_pop = out_valid;

	always_ff @(posedge clk) begin
		if (rst) begin
			take_r <= 1'b0;
		end else begin
			take_r <= word_take;
		end
	end

	// Write pointer
	always_ff @(posedge clk) begin
		if (rst) begin
			buf_wr_r <= 1'b0;
		end else if (buf_push) begin
			buf_wr_r <= ~buf_wr_r;
		end
	end

	// Read pointer
	always_ff @(posedge clk) begin
		if (rst) begin
			buf_rd_r <= 1'b0;
		end else if (buf_pop) begin
			buf_rd_r <= ~buf_rd_r;
		end
	end

	// Fill level
	always_ff @(posedge clk) begin
		if (rst) begin
			buf_cnt_r <= 2'h0;
		end else begin
			buf_cnt_r <= 2'(buf_cnt_r + {1'b0, buf_push} - {1'b0, buf_pop});
		end
	end

	always_ff @(posedge clk) begin
		if (buf_push) begin
			buf_mem_r[buf_wr_r] <= '{value: word_hold_r, drive: 1'b1};
		end
	end

	// Output latches hold until the next valid word
	always_ff @(posedge clk) begin
		if (rst) begin
			driver_outputs <= LATCH_RST; // RULE9
		end else if (buf_pop) begin
			driver_outputs <= buf_mem_r[buf_rd_r].value; // RULE8
		end
	end

	// Enables only ever rise; the float ends with the first valid word
	always_ff @(posedge clk) begin
		if (rst) begin
			driver_outputs_oe <= LATCH_RST; // RULE9
		end else if (buf_pop) begin
			driver_outputs_oe <= {OUT_BITS{buf_mem_r[buf_rd_r].drive}}; // RULE10
		end
	end
endmodule
`default_nettype wire

// [dv/sptl_chk.sv]
// Purpose: Port checker for the latch driver
// Assumes: Host clock idles high between frames
// Notes: Bound to sptl_top
`timescale 1ns/10ps
`default_nettype none
module sptl_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic shift_clock_in,
	input wire logic serial_data_in,
	input wire logic load_window_enable,
	input wire logic [12:0] driver_outputs,
	input wire logic [12:0] driver_outputs_oe
);
	import sptl_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence quiet;
		shift_clock_in [*8] ##1 shift_clock_in [*8];
	endsequence
	a_reset_float: assert property ($fell(rst) |-> driver_outputs_oe == 0 && driver_outputs == 0)
		else $error("outputs not floated");
	a_oe_all_same: assert property (driver_outputs_oe == 0 || &driver_outputs_oe)
		else $error("enables differ");
	a_oe_stays_on: assert property (!$fell(driver_outputs_oe[0]))
		else $error("enables dropped");
	a_out_needs_oe: assert property ($changed(driver_outputs) |-> &driver_outputs_oe)
		else $error("floating latch changed");
	a_load_after_window: assert property ($changed(driver_outputs) |-> !load_window_enable)
		else $error("load inside window");
	a_drive_after_window: assert property ($rose(driver_outputs_oe[0]) |-> !load_window_enable)
		else $error("drive inside window");
	a_hold_in_window: assert property (load_window_enable [*3] |-> $stable(driver_outputs))
		else $error("outputs moved in window");
	a_quiet_hold: assert property (quiet |-> $stable(driver_outputs))
		else $error("outputs moved while idle");
endmodule
bind sptl_top sptl_chk sptl_chk_i (.*);
`default_nettype wire

// [dv/sptl_host.sv]
// Purpose: Host model sending framed words
// Assumes: Burst clock, idle high
// Notes: Idle data inverts on every idle pulse
`timescale 1ns/10ps
`default_nettype none
module sptl_host (
	output logic shift_clock_in,
	output logic serial_data_in,
	output logic load_window_enable
);
	initial begin
		shift_clock_in = 1;
		serial_data_in = 1;
		load_window_enable = 0;
	end
	task send(input logic [15:0] w, input int n);
		for (int i = -2; i <= n; i++) begin
			load_window_enable = i >= 0 && i < n;
			serial_data_in = (i >= 0 && i < n) ? w[i] : ~serial_data_in;
			#16 shift_clock_in = 0;
			#16 shift_clock_in = 1;
		end
	endtask
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Purpose: Frame scenarios for the latch driver
// Assumes: Outputs settle within 12 clk
// Notes: A bad frame must leave ports alone
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import sptl_pkg::*;
	logic clk = 0;
	logic rst = 1;
	wire logic sck, sd, en;
	logic [12:0] q, oe;
	int bad_count = 0;
	int check_count = 0;
	always #2.5 clk = ~clk;
	sptl_host sptl_host_i (.shift_clock_in(sck), .serial_data_in(sd), .load_window_enable(en));
	sptl_top sptl_top_i (.clk(clk), .rst(rst), .shift_clock_in(sck), .serial_data_in(sd),
		.load_window_enable(en), .driver_outputs(q), .driver_outputs_oe(oe));
	task chk(input string nm, input logic [12:0] s, e);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task run(input logic [15:0] w, input int n, input logic [12:0] e, eo);
		sptl_host_i.send(w, n);
		repeat (12) @(posedge clk);
		#1;
		chk("driver_outputs", q, e);
		chk("driver_outputs_oe", oe, eo);
		$display("test done, word %h", w);
	endtask
	task t_bad_start;
		run(16'h34b7, 14, 13'h0000, 13'h0000);
	endtask
	task t_short;
		run(16'h34b6, 13, 13'h0000, 13'h0000);
	endtask
	task t_good;
		run(16'h34b6, 14, 13'h1a5b, 13'h1fff);
	endtask
	task t_long;
		run(16'h14b4, 15, 13'h1a5b, 13'h1fff);
	endtask
	task t_second;
		run(16'h14b4, 14, 13'h0a5a, 13'h1fff);
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#20000;
		bad_count++;
		close_out;
	end
	initial begin
		repeat (5) @(posedge clk);
		#1 rst = 0;
		chk("driver_outputs_oe", oe, 13'h0000);
		t_bad_start;
		t_short;
		t_good;
		t_long;
		t_second;
		close_out;
	end
endmodule
`default_nettype wire
